// ==== include/sram_host_pkg.sv ====
/*
  Constants shared by the host-side controller for a 32-bit asynchronous
  static RAM module with four byte-lane selects.
  Assumes a 10 MHz system clock (100 ns period).
*/
package sram_host_pkg;
  // Geometry
  localparam int ADDR_W  = 19;
  localparam int DATA_W  = 32;
  localparam int LANES   = 4;
  localparam int LANE_W  = 8;
  localparam int ID_W    = 4;

  // Clock
  localparam int CLK_PERIOD_PS = 100000;

  // Times in picoseconds, as printed for the fastest grade
  localparam int ADDR_TO_DATA_PS   = 15000; // address_to_data_delay
  localparam int OE_TO_DATA_PS     = 6000;
  localparam int READ_CYCLE_PS     = 15000;
  localparam int WRITE_PULSE_PS    = 13000; // write_pulse_length
  localparam int ADDR_SETUP_PS     = 3000;
  localparam int DATA_SETUP_PS     = 10000;
  localparam int WRITE_RECOVERY_PS = 3000;  // write_recovery_delay
  localparam int WE_TO_HIZ_PS      = 8000;

  // Least times round up, at least one cycle
  function automatic int min_cycles(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int READ_WAIT_CYC  = min_cycles(ADDR_TO_DATA_PS);
  localparam int SETUP_CYC      = min_cycles(ADDR_SETUP_PS);
  localparam int PULSE_CYC      = min_cycles(WRITE_PULSE_PS > DATA_SETUP_PS ? WRITE_PULSE_PS : DATA_SETUP_PS);
  localparam int RECOVER_CYC    = min_cycles(WRITE_RECOVERY_PS);
  localparam int HIZ_WAIT_CYC   = min_cycles(WE_TO_HIZ_PS);
  localparam int CNT_W          = 4;

  // Depth code seen on the identification pins: 1 = open/NC, 0 = tied low
  localparam logic [3:0] DEPTH_ID_512K = 4'hf;
  localparam logic [3:0] DEPTH_ID_MASK = 4'hf;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_RSETUP  = 3'b001,
    ST_RWAIT   = 3'b010,
    ST_WSETUP  = 3'b011,
    ST_WPULSE  = 3'b100,
    ST_WRECOV  = 3'b101
  } seq_state_t;
endpackage

// ==== include/sram_pins_if.sv ====
/*
  Interface bundling the pin-facing signals of the byte-lane data path.
  Assumes both ends share the host clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface sram_pins_if;
  logic [31:0] wr_data;
  logic [3:0]  lane_en;
  logic        drive;
  logic [31:0] dq_out;
  logic [31:0] dq_oe;
  modport ctrl (output wr_data, output lane_en, output drive);
  modport lane (input wr_data, input lane_en, input drive, output dq_out, output dq_oe);
endinterface
`default_nettype wire

// ==== rtl/sram_lane_drv.sv ====
/*
  Per-lane output driver for the bidirectional data lines.
  Assumes drive and lane enables come from flip-flops in the controller.
*/
`timescale 1ns/1ps
`default_nettype none
module sram_lane_drv (
  sram_pins_if.lane pins
);
  // One byte lane per select; enables follow the lane so unwritten bytes stay released
  for (genvar g = 0; g < sram_host_pkg::LANES; g++) begin : g_lane
    assign pins.dq_out[g*sram_host_pkg::LANE_W +: sram_host_pkg::LANE_W] =
      pins.wr_data[g*sram_host_pkg::LANE_W +: sram_host_pkg::LANE_W];
    assign pins.dq_oe[g*sram_host_pkg::LANE_W +: sram_host_pkg::LANE_W] =
      {sram_host_pkg::LANE_W{pins.drive & pins.lane_en[g]}};
  end
endmodule
`default_nettype wire

// ==== rtl/sram_host_ctrl.sv ====
/*
  Host controller for a 512K x 32 asynchronous static RAM module with four
  active-low byte-lane selects, shared write strobe and output enable.
  Assumes pins are synchronous to clk; the tri-state wire is resolved outside.
*/
`timescale 1ns/1ps
`default_nettype none
module sram_host_ctrl (
  // Clock, enable, reset
  input  wire logic        clk,
  input  wire logic        clk_en,
  input  wire logic        sys_rst,
  // User request
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_write,
  input  wire logic [18:0] req_addr,
  input  wire logic [31:0] req_wdata,
  input  wire logic [3:0]  req_lanes,
  // User response
  output logic             rsp_valid,
  output logic [31:0]      rsp_rdata,
  output logic             depth_ok,
  // Memory module pins
  output logic [18:0]      mem_addr,
  output logic [3:0]       byte_lane_select_n,
  output logic             write_strobe_n,
  output logic             output_enable_n,
  input  wire logic [31:0] bidir_data_lines_in,
  output logic [31:0]      bidir_data_lines_out,
  output logic [31:0]      bidir_data_lines_oe,
  input  wire logic [3:0]  depth_id_pins
);
  // Sequencer state, phase counter and registered write data
  sram_host_pkg::seq_state_t state_r;
  sram_host_pkg::seq_state_t state_nxt;
  logic [sram_host_pkg::CNT_W-1:0] cnt_r;
  logic [31:0] wdata_r;
  logic        drive_r;
  logic        cnt_done;

  sram_pins_if pins ();

  // Lane data path and per-lane output enables
  sram_lane_drv u_drv (
    .pins (pins)
  );

  // Bundle wiring; lane enables follow the registered selects
  assign pins.wr_data         = wdata_r;
  assign pins.lane_en         = ~byte_lane_select_n;
  assign pins.drive           = drive_r;
  assign bidir_data_lines_out = pins.dq_out;
  assign bidir_data_lines_oe  = pins.dq_oe;

  // A request is taken only in idle, so nothing ever queues inside
  assign cnt_done  = (cnt_r == '0);
  assign req_ready = (state_r == sram_host_pkg::ST_IDLE);

  // Next state; every phase waits out its least time in whole cycles
  // Read : idle, address setup, output enable low, data taken at its end
  // Write: idle, address setup, strobe low with data, strobe high with data held
  // Selects fall a cycle before the strobe and rise a cycle after it, so every
  // write is strobe-terminated, and data hold and write recovery are both timed from the strobe's rise
  // Trade-off: at 100 ns a cycle each least time rounds up to a whole cycle,
  // costing throughput but needing no timing finer than the clock
  // A faster clock only needs the package times rounded again
  // Unknown state codes fall back to idle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sram_host_pkg::ST_IDLE:
        if (req_valid) begin
          state_nxt = req_write ? sram_host_pkg::ST_WSETUP : sram_host_pkg::ST_RSETUP;
        end
      sram_host_pkg::ST_RSETUP:
        state_nxt = sram_host_pkg::ST_RWAIT;
      sram_host_pkg::ST_RWAIT:
        if (cnt_done) begin
          state_nxt = sram_host_pkg::ST_IDLE;
        end
      sram_host_pkg::ST_WSETUP:
        if (cnt_done) begin
          state_nxt = sram_host_pkg::ST_WPULSE;
        end
      sram_host_pkg::ST_WPULSE:
        if (cnt_done) begin
          state_nxt = sram_host_pkg::ST_WRECOV;
        end
      sram_host_pkg::ST_WRECOV:
        if (cnt_done) begin
          state_nxt = sram_host_pkg::ST_IDLE;
        end
      default:
        state_nxt = sram_host_pkg::ST_IDLE;
    endcase
  end

  // State register; clock enable low freezes the sequence mid-phase
  // Synchronous reset returns to idle with strobes high and selects released
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= sram_host_pkg::ST_IDLE;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // Phase counter loaded with the remaining cycles of the next phase
  // A zero load means the phase lasts exactly one cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else if (clk_en) begin
      if (state_r != state_nxt) begin
        case (state_nxt)
          sram_host_pkg::ST_RWAIT:  cnt_r <= sram_host_pkg::CNT_W'(sram_host_pkg::READ_WAIT_CYC - 1);
          sram_host_pkg::ST_WSETUP: cnt_r <= sram_host_pkg::CNT_W'(sram_host_pkg::SETUP_CYC - 1);
          sram_host_pkg::ST_WPULSE: cnt_r <= sram_host_pkg::CNT_W'(sram_host_pkg::PULSE_CYC - 1);
          sram_host_pkg::ST_WRECOV: cnt_r <= sram_host_pkg::CNT_W'(sram_host_pkg::RECOVER_CYC - 1);
          default:                  cnt_r <= '0;
        endcase
      end else if (!cnt_done) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // Address and selects load only in idle, when the strobe is high; selects release on the edge back to idle
  // The address stays put until the selects have risen, so it never moves under a low strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_addr           <= '0;
      byte_lane_select_n <= '1;
      wdata_r            <= '0;
    end else if (clk_en) begin
      if (state_r == sram_host_pkg::ST_IDLE && req_valid) begin
        mem_addr           <= req_addr;
        byte_lane_select_n <= ~req_lanes;
        wdata_r            <= req_wdata;
      end else if (state_nxt == sram_host_pkg::ST_IDLE) begin
        byte_lane_select_n <= '1;
      end
    end
  end

  // Strobes: select falls before the strobe, strobe rises before select
  // Output enable and strobe are never low together, so the module never drives into host data
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      write_strobe_n  <= 1'b1;
      output_enable_n <= 1'b1;
    end else if (clk_en) begin
      write_strobe_n  <= ~(state_nxt == sram_host_pkg::ST_WPULSE);
      output_enable_n <= ~(state_nxt == sram_host_pkg::ST_RWAIT);
    end
  end

  // Host drives data only inside the write window, when device outputs are off
  // Drive ends with the selects, a cycle after the strobe, so data holds past the strobe edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drive_r <= 1'b0;
    end else if (clk_en) begin
      drive_r <= (state_nxt == sram_host_pkg::ST_WPULSE) ||
                 (state_nxt == sram_host_pkg::ST_WRECOV);
    end
  end

  // Read capture at the last wait cycle; deselected bytes read as zero
  // Sampled after a full cycle of output enable, well past the access and enable times
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else if (clk_en) begin
      rsp_valid <= 1'b0;
      if (state_r == sram_host_pkg::ST_RWAIT && cnt_done) begin
        rsp_valid <= 1'b1;
        for (int i = 0; i < sram_host_pkg::LANES; i++) begin
          rsp_rdata[i*sram_host_pkg::LANE_W +: sram_host_pkg::LANE_W] <=
            byte_lane_select_n[i] ? '0 : bidir_data_lines_in[i*sram_host_pkg::LANE_W +: sram_host_pkg::LANE_W];
        end
      end
    end
  end

  // Depth identification sampled continuously; pins are static
  // Limitation: a module of another depth only clears the flag; requests are still served
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      depth_ok <= 1'b0;
    end else if (clk_en) begin
      depth_ok <= ((depth_id_pins & sram_host_pkg::DEPTH_ID_MASK) == sram_host_pkg::DEPTH_ID_512K);
    end
  end
endmodule
`default_nettype wire

// ==== dv/sram_model.sv ====
/* Behavioural memory module seen from the controller's pins.
   Assumes the bench wires it to the controller's pin outputs. */
`timescale 1ns/1ps
`default_nettype none
module sram_model (
  // Host-driven pins
  input  wire logic [18:0] addr,
  input  wire logic [3:0]  sel_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [31:0] h_out,
  input  wire logic [31:0] h_oe,
  // Resolved data lines
  output logic      [31:0] bus
);
  logic [31:0] mem [0:524287];
  logic [31:0] en;
  logic [31:0] val;
  logic [31:0] held = 32'h0;
  // Store whatever is on the wire while select and strobe overlap low
  always @* begin
    for (int i = 0; i < 4; i++) begin
      if (!sel_n[i] && !we_n) mem[addr][8*i+:8] = bus[8*i+:8];
    end
  end
  // A lane drives only when selected for a read; deselect is also standby
  always @* begin
    for (int b = 0; b < 32; b++) begin
      en[b]  = h_oe[b] | (!sel_n[b/8] && !oe_n && we_n);
      val[b] = h_oe[b] ? h_out[b] : mem[addr][b];
    end
  end
  // Released lines show the inverse of their last level, never a stale copy
  always @(en or val) held = (en & val) | (~en & held);
  assign bus = (en & val) | (~en & ~held);
endmodule
`default_nettype wire

// ==== dv/sram_host_monitor.sv ====
/* Pin-level checks on the memory host controller.
   Assumes a single clock domain and the bind below. */
`timescale 1ns/1ps
`default_nettype none
module sram_host_monitor (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // User side
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic        req_write,
  input wire logic [3:0]  req_lanes,
  input wire logic        rsp_valid,
  input wire logic        depth_ok,
  // Pins
  input wire logic [18:0] mem_addr,
  input wire logic [3:0]  byte_lane_select_n,
  input wire logic        write_strobe_n,
  input wire logic        output_enable_n,
  input wire logic [31:0] bidir_data_lines_out,
  input wire logic [31:0] bidir_data_lines_oe,
  input wire logic [3:0]  depth_id_pins
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic take;
  // Request accepted at this edge
  assign take = req_valid && req_ready;
  chk_addr_hold: assert property ($changed(mem_addr) |-> (write_strobe_n || &byte_lane_select_n)
    && ($past(write_strobe_n) || &$past(byte_lane_select_n)))
    else $error("address moved during a write");
  chk_no_fight: assert property ((|bidir_data_lines_oe) |-> output_enable_n)
    else $error("host drives while reads are enabled");
  chk_lane_map: assert property (take |=> byte_lane_select_n == ~$past(req_lanes))
    else $error("selects do not follow lane enables");
  chk_sel_first: assert property ($fell(write_strobe_n) |->
    byte_lane_select_n != 4'hf && $stable(byte_lane_select_n) && $stable(mem_addr))
    else $error("select or address not set before strobe");
  chk_pulse_end: assert property ($fell(write_strobe_n) |=>
    write_strobe_n && $stable(bidir_data_lines_out) && (|bidir_data_lines_oe) ##1 byte_lane_select_n == 4'hf)
    else $error("write end sequence wrong");
  chk_read_resp: assert property (take && !req_write |=> !rsp_valid [*2] ##1 rsp_valid)
    else $error("read answer not on third edge");
  chk_write_busy: assert property (take && req_write |=> !req_ready [*3] ##1 req_ready)
    else $error("write length wrong");
  chk_oe_read: assert property (!output_enable_n |-> write_strobe_n)
    else $error("output enable during write");
  chk_depth_flag: assert property (!$past(sys_rst) |-> depth_ok == ($past(depth_id_pins) == 4'hf))
    else $error("depth flag wrong");
endmodule
bind sram_host_ctrl sram_host_monitor i_mon (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
  .req_ready(req_ready), .req_write(req_write), .req_lanes(req_lanes), .rsp_valid(rsp_valid),
  .depth_ok(depth_ok), .mem_addr(mem_addr), .byte_lane_select_n(byte_lane_select_n),
  .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
  .bidir_data_lines_out(bidir_data_lines_out), .bidir_data_lines_oe(bidir_data_lines_oe),
  .depth_id_pins(depth_id_pins));
`default_nettype wire

// ==== dv/tb_top.sv ====
/* Self-checking bench for the memory host controller.
   Assumes the behavioural memory model and a 10 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [18:0] req_addr = 19'h0;
  logic [31:0] req_wdata = 32'h0;
  logic [3:0]  req_lanes = 4'h0;
  logic [3:0]  depth_id_pins = 4'hf;
  logic        req_ready, rsp_valid, depth_ok, write_strobe_n, output_enable_n;
  logic [31:0] rsp_rdata, dq_in, dq_out, dq_oe;
  logic [18:0] mem_addr;
  logic [3:0]  sel_n;
  logic [18:0] ad [8];
  logic [31:0] exp_q [$];
  logic [31:0] shadow [logic [18:0]];
  int          errors = 0;
  int          tests_run = 0;
  // 100 ns clock
  always #50 clk = ~clk;
  sram_host_ctrl i_dut (.clk(clk), .clk_en(1'b1), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_lanes(req_lanes), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .depth_ok(depth_ok),
    .mem_addr(mem_addr), .byte_lane_select_n(sel_n), .write_strobe_n(write_strobe_n),
    .output_enable_n(output_enable_n), .bidir_data_lines_in(dq_in), .bidir_data_lines_out(dq_out),
    .bidir_data_lines_oe(dq_oe), .depth_id_pins(depth_id_pins));
  sram_model i_mem (.addr(mem_addr), .sel_n(sel_n), .we_n(write_strobe_n), .oe_n(output_enable_n),
    .h_out(dq_out), .h_oe(dq_oe), .bus(dq_in));
  task automatic summarize();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cmp_word(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic cmp_flag(input string what, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %b got %b", what, e, g);
    end
  endtask
  // Note the expectation, then hold the request until it is taken
  task automatic op(input logic w, input logic [18:0] a, input logic [31:0] d, input logic [3:0] l);
    logic [31:0] e;
    int          n;
    e = 32'h0;
    n = 0;
    for (int i = 0; i < 4; i++) begin
      if (l[i] && w) shadow[a][8*i+:8] = d[8*i+:8];
      if (l[i]) e[8*i+:8] = shadow[a][8*i+:8];
    end
    if (!w) exp_q.push_back(e);
    @(negedge clk);
    {req_valid, req_write, req_addr, req_wdata, req_lanes} = {1'b1, w, a, d, l};
    while (req_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n >= 20) errors++;
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  // Response watcher: oldest note against each read answer
  always @(posedge clk) begin
    #1;
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) cmp_word("rsp_rdata", 32'hx, rsp_rdata);
      else cmp_word("rsp_rdata", exp_q.pop_front(), rsp_rdata);
    end
  end
  // Watchdog well past the expected run length
  initial begin
    #200000;
    errors++;
    summarize();
  end
  // Main sequence
  initial begin
    void'($urandom(32'ha249ed4a));
    repeat (20) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    for (int v = 0; v < 16; v++) begin
      @(negedge clk);
      depth_id_pins = 4'(v);
      @(negedge clk);
      cmp_flag("depth_ok", v == 15, depth_ok);
    end
    for (int i = 0; i < 8; i++) begin
      ad[i] = (i == 0) ? 19'h0 : (i == 1) ? 19'h7ffff : 19'($urandom);
      op(1'b1, ad[i], $urandom, 4'hf);
    end
    repeat (40) op(1'($urandom_range(1)), ad[$urandom_range(7)], $urandom, 4'($urandom_range(15, 1)));
    // Mid-run reset once the last transfer is over: pins go idle, stored data survives
    repeat (6) @(negedge clk);
    sys_rst = 1'b1;
    @(negedge clk);
    cmp_flag("write_strobe_n", 1'b1, write_strobe_n);
    cmp_word("byte_lane_select_n", 32'hf, 32'(sel_n));
    cmp_flag("depth_ok", 1'b0, depth_ok);
    sys_rst = 1'b0;
    for (int i = 0; i < 8; i++) op(1'b0, ad[i], 32'h0, 4'hf);
    repeat (10) @(posedge clk);
    cmp_word("pending reads", 32'h0, 32'(exp_q.size()));
    summarize();
  end
endmodule
`default_nettype wire
